//--- hdl/sre_pkg.sv
// Purpose: shared constants and types for the serial memory read engine
// Assumes: 250 MHz system clock on both ends
// Notes: the host makes the link clock from its own clock by a divider

package sre_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int SRE_CLK_NS = 4;
	localparam int SRE_SCL_NS = 2500; // link clock period made by the host
	// quarter of a link clock period, rounded up
	localparam int SRE_QTR_CYC = (SRE_SCL_NS + 4 * SRE_CLK_NS - 1) / (4 * SRE_CLK_NS);

	// ****************************************
	// addressing and sizes
	// ****************************************
	localparam logic [6:0] SRE_DEV_ADDR = 7'h3c; // value arbitrary
	localparam logic SRE_RW_READ = 1'b1;
	localparam logic SRE_RW_WRITE = 1'b0;
	localparam int SRE_AW = 8;
	localparam int SRE_FIFO_DEPTH = 32;
	localparam logic [3:0] SRE_ACK_BIT = 4'h8;

	// ****************************************
	// state types
	// ****************************************
	typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK} sre_dstate_type;
	typedef enum logic [1:0] {RK_DEV, RK_WORD, RK_DATA} sre_rkind_type;
	typedef enum logic [2:0] {
		OP_IDLE, OP_START1, OP_WDEV, OP_WWORD, OP_START2, OP_WDEVR, OP_READ, OP_STOP
	} sre_op_type;

endpackage

//--- hdl/sre_if.sv
// Purpose: two-wire link between host end and memory end
// Assumes: sda is open drain with a pull-up, scl is driven by the host only
// Notes: enables are active low; a low enable with low data pulls sda low

`timescale 1ns/1ps

interface sre_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic sda;

	// wired-and of both open-drain drivers
	assign sda = ((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;

	modport host(output scl, output host_sda_o, output host_sda_oe_n, input sda);
	modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

//--- hdl/sre_dev.sv
// Purpose: memory end of the two-wire link, answering reads as a slave
// Assumes: scl and sda come from another domain and are synchronised here
// Notes: word writes are kept so the pointer and array can be set over the link

`timescale 1ns/1ps

// Operation
// - read starts with start, address, rw one
// - current, random and sequential reads supported
// - pointer holds last accessed word plus one
// - on read address: acknowledge, send eight bits
// - master nack and stop end read, release
// - master loads word address in a write
// - repeated start abandons write, keeps pointer
// - master resends address with rw one
// - after random read pointer is next word
// - master ack requests next consecutive byte
// - pointer increments by one per read
module sre_dev
#(
	parameter int AW = sre_pkg::SRE_AW,
	parameter logic [6:0] DEV_ADDR = sre_pkg::SRE_DEV_ADDR
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	sre_if.dev bus,
	input wire logic i_load_en,
	input wire logic [AW-1:0] i_load_addr,
	input wire logic [7:0] i_load_data,
	output logic [AW-1:0] o_ptr,
	output logic o_busy
);
	import sre_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic scl_m_reg, scl_s_reg, scl_d_reg;
	logic sda_m_reg, sda_s_reg, sda_d_reg;
	logic scl_rise, scl_fall, start_evt, stop_evt;
	sre_dstate_type state_reg, state_next;
	sre_rkind_type kind_reg, kind_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [AW-1:0] ptr_reg, ptr_next;
	logic rw_reg, rw_next;
	logic mack_reg, mack_next;
	logic oe_n_reg, oe_n_next;
	logic mem_we;
	logic [7:0] mem [0:(2**AW)-1];
	logic [7:0] mem_word;

	// pointer step, natural wrap at the top of the array
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return p + 1'b1;
	endfunction

	// ****************************************
	// link input synchronisers
	// ****************************************
	// two flops per pin, a third for edge detection
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_m_reg <= bus.scl;
			scl_s_reg <= scl_m_reg;
			scl_d_reg <= scl_s_reg;
			sda_m_reg <= bus.sda;
			sda_s_reg <= sda_m_reg;
			sda_d_reg <= sda_s_reg;
		end
	end

	// edges and bus conditions
	assign scl_rise = scl_s_reg && !scl_d_reg;
	assign scl_fall = !scl_s_reg && scl_d_reg;
	assign start_evt = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
	assign stop_evt = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;

	// word at the pointer, fed to the transmit shifter
	assign mem_word = mem[ptr_reg];

	// ****************************************
	// protocol engine
	// ****************************************
	// next-state logic
	always_comb
	begin
		state_next = state_reg;
		kind_next = kind_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		rw_next = rw_reg;
		mack_next = mack_reg;
		oe_n_next = oe_n_reg;
		mem_we = 1'b0;
		if (start_evt)
		begin
			// start or repeated start: abandon any transfer, keep pointer
			state_next = DS_RX;
			kind_next = RK_DEV;
			cnt_next = 4'h0;
			oe_n_next = 1'b1;
		end
		else if (stop_evt)
		begin
			state_next = DS_IDLE;
			oe_n_next = 1'b1;
		end
		else
		begin
			unique case (state_reg)
				DS_IDLE:
				begin
					oe_n_next = 1'b1;
				end
				DS_RX:
				begin
					if (scl_rise)
					begin
						shift_next = {shift_reg[6:0], sda_s_reg};
						cnt_next = cnt_reg + 4'h1;
					end
					else if (scl_fall && cnt_reg == SRE_ACK_BIT)
					begin
						state_next = DS_ACK;
						oe_n_next = 1'b0; // acknowledge
						unique case (kind_reg)
							RK_DEV:
							begin
								rw_next = shift_reg[0];
								if (shift_reg[7:1] != DEV_ADDR)
								begin
									state_next = DS_IDLE;
									oe_n_next = 1'b1;
								end
							end
							RK_WORD:
							begin
								ptr_next = AW'(shift_reg);
							end
							default:
							begin
								mem_we = 1'b1;
								ptr_next = ptr_inc(ptr_reg);
							end
						endcase
					end
				end
				DS_ACK:
				begin
					if (scl_fall)
					begin
						if (rw_reg == SRE_RW_READ)
						begin
							// first byte of a read goes out at the pointer
							tx_next = mem_word;
							oe_n_next = mem_word[7];
							ptr_next = ptr_inc(ptr_reg);
							cnt_next = 4'h1;
							state_next = DS_TX;
						end
						else
						begin
							state_next = DS_RX;
							kind_next = (kind_reg == RK_DEV) ? RK_WORD : RK_DATA;
							cnt_next = 4'h0;
							oe_n_next = 1'b1;
						end
					end
				end
				DS_TX:
				begin
					if (scl_fall)
					begin
						if (cnt_reg == SRE_ACK_BIT)
						begin
							oe_n_next = 1'b1; // free sda for master ack
							state_next = DS_MACK;
						end
						else
						begin
							tx_next = {tx_reg[6:0], 1'b0};
							oe_n_next = tx_reg[6];
							cnt_next = cnt_reg + 4'h1;
						end
					end
				end
				DS_MACK:
				begin
					if (scl_rise)
					begin
						mack_next = !sda_s_reg;
					end
					else if (scl_fall)
					begin
						if (mack_reg)
						begin
							// master ack: next consecutive word
							tx_next = mem_word;
							oe_n_next = mem_word[7];
							ptr_next = ptr_inc(ptr_reg);
							cnt_next = 4'h1;
							state_next = DS_TX;
						end
						else
						begin
							state_next = DS_IDLE;
							oe_n_next = 1'b1;
						end
					end
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_reg <= DS_IDLE;
			kind_reg <= RK_DEV;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= '0;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			rw_reg <= rw_next;
			mack_reg <= mack_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// ****************************************
	// storage array
	// ****************************************
	// link write wins over the user-side load port
	always_ff @(posedge i_clk)
	begin
		if (mem_we)
		begin
			mem[ptr_reg] <= shift_reg;
		end
		else if (i_load_en)
		begin
			mem[i_load_addr] <= i_load_data;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// open drain: data low, enable decides
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = oe_n_reg;
	assign o_ptr = ptr_reg;
	assign o_busy = (state_reg != DS_IDLE);
endmodule

//--- hdl/sre_host.sv
// Purpose: host end of the two-wire link, issuing the three read kinds
// Assumes: makes scl by dividing i_clk; received bytes pass a FIFO
// Notes: scl is held low while the FIFO is full, which stalls the link

`timescale 1ns/1ps

// ****************************************
// receive FIFO
// ****************************************
module sre_fifo
#(
	parameter int W = 8,
	parameter int DEPTH = sre_pkg::SRE_FIFO_DEPTH
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	import sre_pkg::*;

	localparam int PW = $clog2(DEPTH);
	logic [PW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [W-1:0] mem [0:DEPTH-1];
	logic push, pop;

	// full when pointers differ only in the wrap bit
	assign o_in_ready = !((wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]));
	assign o_out_valid = (wr_reg != rd_reg);
	assign o_out_data = mem[rd_reg[PW-1:0]];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	// pointer advance
	always_comb
	begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	// pointer registers
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// storage
	always_ff @(posedge i_clk)
	begin
		if (push)
		begin
			mem[wr_reg[PW-1:0]] <= i_in_data;
		end
	end
endmodule

// ****************************************
// host engine
// ****************************************
module sre_host
#(
	parameter int QTR = sre_pkg::SRE_QTR_CYC,
	parameter logic [6:0] DEV_ADDR = sre_pkg::SRE_DEV_ADDR,
	parameter int FIFO_DEPTH = sre_pkg::SRE_FIFO_DEPTH
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	sre_if.host bus,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic i_cmd_rand,
	input wire logic [7:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_len,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [7:0] o_rd_data,
	output logic o_busy,
	output logic o_nack
);
	import sre_pkg::*;

	sre_op_type op_reg, op_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_reg, bit_next;
	logic [15:0] q_reg, q_next;
	logic [7:0] tx_reg, tx_next, rx_reg, rx_next, left_reg, left_next, addr_reg, addr_next;
	logic rand_reg, rand_next, ack_reg, ack_next, pend_reg, pend_next, nack_reg, nack_next;
	logic scl_reg, scl_next, oe_reg, oe_next;
	logic sda_m_reg, sda_s_reg;
	logic tick, is_byte, fifo_ready;

	// two-flop synchroniser on returning sda
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
		end
		else
		begin
			sda_m_reg <= bus.sda;
			sda_s_reg <= sda_m_reg;
		end
	end

	// quarter-period tick, frozen while a byte waits for the FIFO
	assign tick = (q_reg == 16'(QTR - 1)) && !pend_reg;
	assign is_byte = (op_reg == OP_WDEV) || (op_reg == OP_WWORD) ||
		(op_reg == OP_WDEVR) || (op_reg == OP_READ);

	// sequencer
	always_comb
	begin
		op_next = op_reg;
		ph_next = ph_reg;
		bit_next = bit_reg;
		q_next = q_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		left_next = left_reg;
		addr_next = addr_reg;
		rand_next = rand_reg;
		ack_next = ack_reg;
		pend_next = pend_reg;
		nack_next = nack_reg;
		if (op_reg == OP_IDLE)
		begin
			if (i_cmd_valid)
			begin
				op_next = OP_START1;
				rand_next = i_cmd_rand;
				addr_next = i_cmd_addr;
				left_next = (i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
				nack_next = 1'b0;
				ph_next = 2'h0;
				bit_next = 4'h0;
				q_next = 16'h0000;
			end
		end
		else
		begin
			if (pend_reg && fifo_ready)
			begin
				pend_next = 1'b0;
			end
			if (!pend_reg)
			begin
				q_next = tick ? 16'h0000 : q_reg + 16'h0001;
			end
			if (tick)
			begin
				// sample mid high phase
				if (ph_reg == 2'h2 && is_byte)
				begin
					if (bit_reg == SRE_ACK_BIT)
					begin
						ack_next = !sda_s_reg;
					end
					else if (op_reg == OP_READ)
					begin
						rx_next = {rx_reg[6:0], sda_s_reg};
					end
				end
				if (ph_reg != 2'h3)
				begin
					ph_next = ph_reg + 2'h1;
				end
				else if (is_byte && bit_reg != SRE_ACK_BIT)
				begin
					ph_next = 2'h0;
					bit_next = bit_reg + 4'h1;
					tx_next = {tx_reg[6:0], 1'b0};
					pend_next = (op_reg == OP_READ) && (bit_reg == 4'h7);
				end
				else
				begin
					ph_next = 2'h0;
					bit_next = 4'h0;
					unique case (op_reg)
						OP_START1:
						begin
							op_next = OP_WDEV;
							tx_next = {DEV_ADDR, rand_reg ? SRE_RW_WRITE : SRE_RW_READ};
						end
						OP_WDEV:
						begin
							nack_next = !ack_reg;
							op_next = !ack_reg ? OP_STOP : (rand_reg ? OP_WWORD : OP_READ);
							tx_next = addr_reg;
						end
						OP_WWORD:
						begin
							nack_next = !ack_reg;
							op_next = !ack_reg ? OP_STOP : OP_START2;
						end
						OP_START2:
						begin
							op_next = OP_WDEVR;
							tx_next = {DEV_ADDR, SRE_RW_READ};
						end
						OP_WDEVR:
						begin
							nack_next = !ack_reg;
							op_next = !ack_reg ? OP_STOP : OP_READ;
						end
						OP_READ:
						begin
							// last byte ends with stop, else continue
							if (left_reg == 8'h01)
							begin
								op_next = OP_STOP;
							end
							else
							begin
								left_next = left_reg - 8'h01;
							end
						end
						OP_STOP:
						begin
							op_next = OP_IDLE;
						end
						default:
						begin
							op_next = OP_IDLE;
						end
					endcase
				end
			end
		end
	end

	// pin drive, one cycle behind the sequencer
	always_comb
	begin
		scl_next = 1'b1;
		oe_next = 1'b1;
		unique case (op_reg)
			OP_IDLE:
			begin
				scl_next = 1'b1;
				oe_next = 1'b1;
			end
			OP_START1, OP_START2:
			begin
				scl_next = (ph_reg != 2'h0);
				oe_next = (ph_reg < 2'h2);
			end
			OP_STOP:
			begin
				scl_next = (ph_reg != 2'h0);
				oe_next = (ph_reg >= 2'h2);
			end
			default:
			begin
				scl_next = ph_reg[1];
				if (bit_reg == SRE_ACK_BIT)
				begin
					// ack all but the last read byte
					oe_next = (op_reg == OP_READ) ? (left_reg == 8'h01) : 1'b1;
				end
				else
				begin
					oe_next = (op_reg == OP_READ) ? 1'b1 : tx_reg[7];
				end
			end
		endcase
	end

	// registers
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			op_reg <= OP_IDLE;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			q_reg <= 16'h0000;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			left_reg <= 8'h00;
			addr_reg <= 8'h00;
			rand_reg <= 1'b0;
			ack_reg <= 1'b0;
			pend_reg <= 1'b0;
			nack_reg <= 1'b0;
			scl_reg <= 1'b1;
			oe_reg <= 1'b1;
		end
		else
		begin
			op_reg <= op_next;
			ph_reg <= ph_next;
			bit_reg <= bit_next;
			q_reg <= q_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			left_reg <= left_next;
			addr_reg <= addr_next;
			rand_reg <= rand_next;
			ack_reg <= ack_next;
			pend_reg <= pend_next;
			nack_reg <= nack_next;
			scl_reg <= scl_next;
			oe_reg <= oe_next;
		end
	end

	// received bytes buffered toward the user
	sre_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in_valid(pend_reg),
		.o_in_ready(fifo_ready),
		.i_in_data(rx_reg),
		.o_out_valid(o_rd_valid),
		.i_out_ready(i_rd_ready),
		.o_out_data(o_rd_data)
	);

	assign bus.scl = scl_reg;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = oe_reg;
	assign o_cmd_ready = (op_reg == OP_IDLE);
	assign o_busy = (op_reg != OP_IDLE);
	assign o_nack = nack_reg;
endmodule

//--- tb/sre_monitor.sv
// Purpose: watch the two-wire link between the host end and the memory end
// Assumes: one clock domain; i_clk samples the wire directly
// Notes: helpers count link clock rises from each start or stop condition

`timescale 1ns/1ps

module sre_monitor
#(
	parameter int QTR = sre_pkg::SRE_QTR_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic sda
);
	import sre_pkg::*;

	// ****************************************
	// framing helpers
	// ****************************************
	logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next, rd_reg, rd_next;
	logic [15:0] run_reg, run_next;
	logic [11:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic rise, start, stop;

	// link clock edge and start/stop decode
	assign rise = scl && !scl_q_reg;
	assign start = scl && scl_q_reg && sda_q_reg && !sda;
	assign stop = scl && scl_q_reg && !sda_q_reg && sda;

	// next values: run length, bit count, shifted bits, direction
	always_comb
	begin
		scl_q_next = scl;
		sda_q_next = sda;
		run_next = (scl == scl_q_reg) ? run_reg + 16'h1 : 16'h0;
		cnt_next = (start || stop) ? 12'h0 : (rise ? cnt_reg + 12'h1 : cnt_reg);
		sh_next = rise ? {sh_reg[6:0], sda} : sh_reg;
		rd_next = (rise && cnt_reg == 12'h7) ? sda : rd_reg;
	end

	// helper registers
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			run_reg <= 16'h0;
			cnt_reg <= 12'h0;
			sh_reg <= 8'h00;
			rd_reg <= 1'b0;
		end
		else
		begin
			scl_q_reg <= scl_q_next;
			sda_q_reg <= sda_q_next;
			run_reg <= run_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			rd_reg <= rd_next;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_reset_idle: assert property (disable iff (1'b0)
		i_rst |=> scl && host_sda_oe_n && dev_sda_oe_n)
		else $error("link not idle after reset");
	a_open_drain: assert property (!host_sda_o && !dev_sda_o)
		else $error("data wire driven high by an end");
	a_scl_high_min: assert property (scl != scl_q_reg && !scl |->
		int'(run_reg) >= 2 * QTR - 2)
		else $error("link clock high phase too short");
	a_scl_low_min: assert property (scl != scl_q_reg && scl |-> int'(run_reg) >= QTR - 2)
		else $error("link clock low phase too short");
	a_dev_when_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("memory end changed data while clock high");
	a_dev_setup: assert property ($fell(dev_sda_oe_n) |-> !scl && !$past(scl, 3))
		else $error("memory end drove too soon after clock fall");
	a_frame_bits: assert property (start || stop |-> cnt_reg % 12'h9 == 12'h1)
		else $error("start or stop not on a nine bit boundary");
	a_addr_ack: assert property (rise && cnt_reg == 12'h8 &&
		sh_reg[7:1] == SRE_DEV_ADDR |-> !dev_sda_oe_n && !sda)
		else $error("own address not acknowledged");
	a_addr_quiet: assert property (rise && cnt_reg < 12'h8 |-> dev_sda_oe_n)
		else $error("memory end drove during address byte");
	a_mack_release: assert property (rise && rd_reg && cnt_reg > 12'h10 &&
		cnt_reg % 12'h9 == 12'h8 |-> dev_sda_oe_n)
		else $error("memory end drove the master acknowledge slot");
	a_stop_release: assert property (stop |-> dev_sda_oe_n [*8])
		else $error("memory end drove after stop");
endmodule

//--- tb/tb.sv
// Purpose: end-to-end bench of the host end and memory end of the read link
// Assumes: shortened quarter period; main pair shares the default address
// Notes: array preloaded through the load port; a local copy gives expectations

`timescale 1ns/1ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
	import sre_pkg::*;

	localparam int QTR = 8;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic cmd_valid = 1'b0, cmd_rand = 1'b0, rd_ready = 1'b0, load_en = 1'b0;
	logic [7:0] cmd_addr = 8'h00, cmd_len = 8'h00, load_addr = 8'h00, load_data = 8'h00;
	logic cmd_ready, rd_valid, host_busy, nack, dev_busy;
	logic [7:0] rd_data, ptr;
	logic [7:0] mem [256];
	logic [7:0] exp_ptr = 8'h00;
	logic cmd2_valid = 1'b0;
	logic cmd2_ready, rd2_valid, nack2, dev2_busy;
	logic [7:0] ptr2;
	int num_errors = 0;
	int num_checks = 0;

	// ****************************************
	// ends, link and checker
	// ****************************************
	sre_if intf();
	sre_host #(.QTR(QTR)) sre_host_i (.i_clk(i_clk), .i_rst(i_rst), .bus(intf.host),
		.i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_rand(cmd_rand),
		.i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .o_rd_valid(rd_valid),
		.i_rd_ready(rd_ready), .o_rd_data(rd_data), .o_busy(host_busy), .o_nack(nack));
	sre_dev sre_dev_i (.i_clk(i_clk), .i_rst(i_rst), .bus(intf.dev), .i_load_en(load_en),
		.i_load_addr(load_addr), .i_load_data(load_data), .o_ptr(ptr), .o_busy(dev_busy));
	sre_monitor #(.QTR(QTR)) sre_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .scl(intf.scl),
		.host_sda_o(intf.host_sda_o), .host_sda_oe_n(intf.host_sda_oe_n),
		.dev_sda_o(intf.dev_sda_o), .dev_sda_oe_n(intf.dev_sda_oe_n), .sda(intf.sda));
	// second pair whose memory end answers another address: refused-address path
	sre_if intf2();
	sre_host #(.QTR(QTR)) sre_host_i2 (.i_clk(i_clk), .i_rst(i_rst), .bus(intf2.host),
		.i_cmd_valid(cmd2_valid), .o_cmd_ready(cmd2_ready), .i_cmd_rand(cmd_rand),
		.i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .o_rd_valid(rd2_valid),
		.i_rd_ready(rd_ready), .o_rd_data(), .o_busy(), .o_nack(nack2));
	sre_dev #(.DEV_ADDR(7'h2b)) sre_dev_i2 (.i_clk(i_clk), .i_rst(i_rst), .bus(intf2.dev),
		.i_load_en(load_en), .i_load_addr(load_addr), .i_load_data(load_data), .o_ptr(ptr2),
		.o_busy(dev2_busy));

	// 250 MHz clock
	always #2 i_clk = ~i_clk;

	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one read command; wire address byte, data, pointer and idle link compared
	task automatic rd(input logic rnd, input logic [7:0] addr, input logic [7:0] len,
		input int stall);
		logic [7:0] first;
		logic [7:0] wire_byte;
		int n;
		int got;
		int t;
		first = rnd ? addr : exp_ptr;
		n = (len == 8'h00) ? 1 : int'(len);
		got = 0;
		wire_byte = 8'h00;
		rd_ready = (stall == 0);
		cmd_valid = 1'b1;
		cmd_rand = rnd;
		cmd_addr = addr;
		cmd_len = len;
		@(negedge i_clk);
		cmd_valid = 1'b0;
		`CHK(host_busy, 1'b1)
		`CHK(cmd_ready, 1'b0)
		// start rise, then eight address bits
		repeat (9)
		begin
			@(posedge intf.scl);
			wire_byte = {wire_byte[6:0], intf.sda};
		end
		@(negedge i_clk);
		`CHK(wire_byte, {SRE_DEV_ADDR, !rnd})
		if (stall > 0)
		begin
			repeat (stall) @(negedge i_clk);
			`CHK({host_busy, rd_valid, intf.scl}, 3'h6)
			rd_ready = 1'b1;
		end
		for (t = 0; t < 40000 && got < n; t++)
		begin
			if (rd_valid === 1'b1)
			begin
				`CHK(rd_data, mem[8'(first + got)])
				got++;
			end
			@(negedge i_clk);
		end
		for (t = 0; t < 2000 && cmd_ready !== 1'b1; t++)
			@(negedge i_clk);
		exp_ptr = 8'(first + n);
		`CHK(got, n)
		`CHK(ptr, exp_ptr)
		`CHK(nack, 1'b0)
		`CHK(rd_valid, 1'b0)
		`CHK({intf.scl, intf.sda, dev_busy}, 3'h6)
		$display("read done from %h count %0d", first, n);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (16) @(negedge i_clk);
		i_rst = 1'b0;
		`CHK(ptr, 8'h00)
		`CHK({cmd_ready, host_busy, dev_busy}, 3'h4)
		// preload the whole array with distinct words
		load_en = 1'b1;
		for (int i = 0; i < 256; i++)
		begin
			load_addr = 8'(i);
			load_data = 8'(i * 37) ^ 8'h5a;
			mem[i] = load_data;
			@(negedge i_clk);
		end
		load_en = 1'b0;
		rd(1'b0, 8'h00, 8'h01, 0);
		rd(1'b0, 8'h00, 8'h00, 0);
		rd(1'b1, 8'h40, 8'h01, 0);
		rd(1'b0, 8'h00, 8'h01, 0);
		rd(1'b1, 8'hfd, 8'h05, 0);
		rd(1'b0, 8'h00, 8'h28, 12000);
		// refused address on the second pair: no ack, stop, no data
		cmd_rand = 1'b0;
		cmd_len = 8'h01;
		cmd2_valid = 1'b1;
		@(negedge i_clk);
		cmd2_valid = 1'b0;
		for (int t = 0; t < 2000 && cmd2_ready !== 1'b1; t++)
			@(negedge i_clk);
		`CHK({nack2, rd2_valid, dev2_busy}, 3'h4)
		`CHK(ptr2, 8'h00)
		$display("refused address done");
		end_sim();
	end

	// watchdog against a hung link
	initial
	begin
		repeat (60000) @(posedge i_clk);
		num_errors++;
		$display("watchdog expired");
		end_sim();
	end
endmodule
